// *** src/acs_pkg.sv ***
// package for the converter sequence and dac auto-clear block
package acs_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_ALARM_CTRL = 8'h4C;
  localparam logic [7:0] IDX_STATUS = 8'h4F;
  localparam logic [7:0] IDX_CSEL_LO = 8'h50;
  localparam logic [7:0] IDX_CSEL_HI = 8'h51;
  localparam logic [7:0] IDX_RANGE = 8'h52;
  localparam logic [7:0] IDX_SRC = 8'h53;
  localparam logic [7:0] IDX_AEN = 8'h54;
  localparam logic [7:0] IDX_SWCLR = 8'h55;
  localparam logic [7:0] IDX_SEQ = 8'h70;
  // writable bit masks and the status flag mask; other bits read zero
  localparam logic [15:0] MASK_CSEL_LO = 16'h7FFF;
  localparam logic [15:0] MASK_CSEL_HI = 16'h7000;
  localparam logic [15:0] MASK_SRC = 16'h7FFC;
  localparam logic [15:0] MASK_DAC = 16'h7FF8;
  localparam logic [15:0] MASK_ACTL = 16'h0004;
  localparam logic [15:0] MASK_FLAGS = 16'h7FFC;
  // reset values
  localparam logic [15:0] RST_CSEL = 16'h0000;
  localparam logic [15:0] RST_RANGE = 16'hFFFF;
  localparam logic [15:0] RST_SRC = 16'h0004;
  localparam logic [15:0] RST_DAC = 16'h0000;
  localparam logic [15:0] RST_ACTL = 16'h0000;
  // field positions
  localparam int BIT_LATCH_DIS = 2;
  localparam int BIT_OVERTEMP = 2;
  localparam int BIT_PAIR01 = 12;
  localparam int BIT_PAIR23 = 9;
  localparam int DAC_LSB = 3;
  localparam int NUM_DAC = 12;
  localparam int NUM_SLOT = 18;
  localparam logic [4:0] LAST_SLOT = 5'h11;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {SEQ_IDLE, SEQ_SCAN, SEQ_WAIT} acs_seq_e;

  // request to the converter core
  typedef struct packed {
    logic start;
    logic [3:0] chan;
    logic diff;
    logic range;
  } acs_conv_s;

  // result write towards the data registers
  typedef struct packed {
    logic we;
    logic [3:0] idx;
    logic [11:0] data;
    logic twos;
  } acs_res_s;
endpackage

// *** src/acs_top.sv ***
// register file, conversion sequencer and dac auto-clear logic
`timescale 1ns/1ps
`default_nettype none
module acs_top #(
  parameter int ADDR_W = 12
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] alarm_cond,
  input wire logic cycle_done,
  input wire logic conv_done,
  input wire logic [11:0] conv_data,
  output acs_pkg::acs_conv_s conv_req,
  output acs_pkg::acs_res_s result,
  output logic [15:0] input_range_bit,
  output logic [11:0] dac_clear
);

  // elaboration check: index field needs address bits 9:2
  if (ADDR_W < 10) begin : g_bad_addr
    $error("acs_top: ADDR_W must be at least 10");
  end

  typedef struct packed {
    logic [15:0] csel_lo;
    logic [15:0] csel_hi;
    logic [15:0] range;
    logic [15:0] src;
    logic [15:0] aen;
    logic [15:0] swclr;
    logic [15:0] actl;
    logic [15:0] flags;
    acs_pkg::acs_seq_e seq;
    logic [4:0] slot;
    acs_pkg::acs_conv_s conv;
    acs_pkg::acs_res_s res;
    logic [11:0] dac_clr;
    logic aw_got;
    logic [7:0] aw_idx;
    logic w_got;
    logic [15:0] wdata;
    logic [1:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [15:0] rdata;
    logic [1:0] rresp;
  } acs_state_s;

  acs_state_s q;
  acs_state_s d;
  logic [acs_pkg::NUM_SLOT-1:0] slot_en;
  logic [11:0] alarm_clr;

  // slot to input channel: low bits 14..0 then high bits 14..12
  function automatic logic [3:0] slot_chan(input logic [4:0] s);
    logic [3:0] c;
    c = 4'h0;
    case (s)
      5'h00: c = 4'h0;
      5'h01: c = 4'h1;
      5'h02: c = 4'h0;
      5'h03: c = 4'h2;
      5'h04: c = 4'h3;
      5'h05: c = 4'h2;
      5'h0F: c = 4'hD;
      5'h10: c = 4'hE;
      5'h11: c = 4'hF;
      default: c = 4'(s - 5'h02);
    endcase
    return c;
  endfunction

  // per-slot enable with pair bits masked by the single-ended bits
  always_comb begin
    for (int k = 0; k < 15; k++) begin
      slot_en[k] = q.csel_lo[14-k];
    end
    slot_en[14-acs_pkg::BIT_PAIR01] = q.csel_lo[acs_pkg::BIT_PAIR01] &
      ~q.csel_lo[14] & ~q.csel_lo[13];
    slot_en[14-acs_pkg::BIT_PAIR23] = q.csel_lo[acs_pkg::BIT_PAIR23] &
      ~q.csel_lo[11] & ~q.csel_lo[10];
    for (int k = 15; k < acs_pkg::NUM_SLOT; k++) begin
      slot_en[k] = q.csel_hi[29-k];
    end
  end

  // alarm-forced clear per dac, independent of dac operating mode
  for (genvar n = 0; n < acs_pkg::NUM_DAC; n++) begin : g_dac
    assign alarm_clr[n] =
      (|(q.flags[14:3] & q.src[14:3]) & q.aen[acs_pkg::DAC_LSB+n]) |
      (q.flags[acs_pkg::BIT_OVERTEMP] & q.src[acs_pkg::BIT_OVERTEMP]);
  end

  // next-state logic for the whole block
  always_comb begin
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    logic do_wr;
    logic [15:0] bmask;
    logic [15:0] wv;
    logic [7:0] r_idx;
    logic rd_status;
    logic wr_hit;
    // defaults so every local holds a value on every path
    do_wr = 1'b0;
    bmask = 16'h0000;
    wv = 16'h0000;
    r_idx = 8'h00;
    rd_status = 1'b0;
    wr_hit = 1'b1;
    aw_hs = s_axi_awvalid & q.awready;
    w_hs = s_axi_wvalid & q.wready;
    ar_hs = s_axi_arvalid & q.arready;
    d = q;
    d.conv.start = 1'b0;
    d.res.we = 1'b0;
    // write address and data taken independently
    if (aw_hs) begin
      d.aw_got = 1'b1;
      d.aw_idx = s_axi_awaddr[9:2];
    end
    if (w_hs) begin
      d.w_got = 1'b1;
      d.wdata = s_axi_wdata[15:0];
      d.wstrb = s_axi_wstrb[1:0];
    end
    do_wr = d.aw_got & d.w_got & ~q.bvalid;
    bmask = {{8{d.wstrb[1]}}, {8{d.wstrb[0]}}};
    wr_hit = 1'b1;
    if (do_wr) begin
      d.aw_got = 1'b0;
      d.w_got = 1'b0;
      d.bvalid = 1'b1;
      case (d.aw_idx)
        acs_pkg::IDX_CSEL_LO: begin
          wv = acs_pkg::MASK_CSEL_LO & bmask;
          d.csel_lo = (q.csel_lo & ~wv) | (d.wdata & wv);
        end
        acs_pkg::IDX_CSEL_HI: begin
          wv = acs_pkg::MASK_CSEL_HI & bmask;
          d.csel_hi = (q.csel_hi & ~wv) | (d.wdata & wv);
        end
        acs_pkg::IDX_RANGE: begin
          d.range = (q.range & ~bmask) | (d.wdata & bmask);
        end
        acs_pkg::IDX_SRC: begin
          wv = acs_pkg::MASK_SRC & bmask;
          d.src = (q.src & ~wv) | (d.wdata & wv);
        end
        acs_pkg::IDX_AEN: begin
          wv = acs_pkg::MASK_DAC & bmask;
          d.aen = (q.aen & ~wv) | (d.wdata & wv);
        end
        acs_pkg::IDX_SWCLR: begin
          wv = acs_pkg::MASK_DAC & bmask;
          d.swclr = (q.swclr & ~wv) | (d.wdata & wv);
        end
        acs_pkg::IDX_ALARM_CTRL: begin
          wv = acs_pkg::MASK_ACTL & bmask;
          d.actl = (q.actl & ~wv) | (d.wdata & wv);
        end
        acs_pkg::IDX_STATUS: wr_hit = 1'b1;
        acs_pkg::IDX_SEQ: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
      endcase
      d.bresp = wr_hit ? acs_pkg::RESP_OKAY : acs_pkg::RESP_SLVERR;
    end else if (q.bvalid & s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    d.awready = ~d.aw_got & ~d.bvalid;
    d.wready = ~d.w_got & ~d.bvalid;
    // read: data one cycle after the address is taken
    r_idx = s_axi_araddr[9:2];
    rd_status = ar_hs & (r_idx == acs_pkg::IDX_STATUS);
    if (ar_hs) begin
      d.rvalid = 1'b1;
      d.rresp = acs_pkg::RESP_OKAY;
      case (r_idx)
        acs_pkg::IDX_CSEL_LO: d.rdata = q.csel_lo;
        acs_pkg::IDX_CSEL_HI: d.rdata = q.csel_hi;
        acs_pkg::IDX_RANGE: d.rdata = q.range;
        acs_pkg::IDX_SRC: d.rdata = q.src;
        acs_pkg::IDX_AEN: d.rdata = q.aen;
        acs_pkg::IDX_SWCLR: d.rdata = q.swclr;
        acs_pkg::IDX_ALARM_CTRL: d.rdata = q.actl;
        acs_pkg::IDX_STATUS: d.rdata = q.flags;
        acs_pkg::IDX_SEQ: d.rdata = {8'h00, q.slot, q.conv.diff, q.seq};
        default: begin
          d.rdata = 16'h0000;
          d.rresp = acs_pkg::RESP_SLVERR;
        end
      endcase
    end else if (q.rvalid & s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    d.arready = ~d.rvalid;
    // alarm flags: follow condition, or latch until gone and read
    if (q.actl[acs_pkg::BIT_LATCH_DIS]) begin
      d.flags = alarm_cond & acs_pkg::MASK_FLAGS;
    end else begin
      if (rd_status) begin
        d.flags = q.flags & alarm_cond;
      end
      if (cycle_done) begin
        d.flags = d.flags | (alarm_cond & acs_pkg::MASK_FLAGS);
      end
    end
    // dac clear output, held while its causes stay asserted
    d.dac_clr = alarm_clr | q.swclr[14:3];
    // conversion sequencer
    case (q.seq)
      acs_pkg::SEQ_IDLE: begin
        d.slot = 5'h00;
        if (|slot_en) begin
          d.seq = acs_pkg::SEQ_SCAN;
        end
      end
      acs_pkg::SEQ_SCAN: begin
        if (~|slot_en) begin
          d.seq = acs_pkg::SEQ_IDLE;
        end else if (slot_en[q.slot]) begin
          d.conv.start = 1'b1;
          d.conv.chan = slot_chan(q.slot);
          d.conv.diff = (q.slot == 5'h02) | (q.slot == 5'h05);
          d.conv.range = q.range[4'hF - slot_chan(q.slot)];
          d.seq = acs_pkg::SEQ_WAIT;
        end else begin
          d.slot = (q.slot == acs_pkg::LAST_SLOT) ? 5'h00 : q.slot + 5'h01;
        end
      end
      acs_pkg::SEQ_WAIT: begin
        if (conv_done) begin
          d.res.we = 1'b1;
          d.res.idx = q.conv.chan;
          d.res.data = conv_data;
          d.res.twos = q.conv.diff;
          d.slot = (q.slot == acs_pkg::LAST_SLOT) ? 5'h00 : q.slot + 5'h01;
          d.seq = acs_pkg::SEQ_SCAN;
        end
      end
      default: d.seq = acs_pkg::SEQ_IDLE;
    endcase
  end

  // state register with synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
      q.csel_lo <= acs_pkg::RST_CSEL;
      q.csel_hi <= acs_pkg::RST_CSEL;
      q.range <= acs_pkg::RST_RANGE;
      q.src <= acs_pkg::RST_SRC;
      q.aen <= acs_pkg::RST_DAC;
      q.swclr <= acs_pkg::RST_DAC;
      q.actl <= acs_pkg::RST_ACTL;
      q.seq <= acs_pkg::SEQ_IDLE;
    end else begin
      q <= d;
    end
  end

  // outputs straight from the state register
  assign s_axi_awready = q.awready;
  assign s_axi_wready = q.wready;
  assign s_axi_bvalid = q.bvalid;
  assign s_axi_bresp = q.bresp;
  assign s_axi_arready = q.arready;
  assign s_axi_rvalid = q.rvalid;
  assign s_axi_rdata = {16'h0000, q.rdata};
  assign s_axi_rresp = q.rresp;
  assign conv_req = q.conv;
  assign result = q.res;
  assign input_range_bit = q.range;
  assign dac_clear = q.dac_clr;

  // checks on the block's own behaviour
  chk_reserved_zero: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.csel_lo[15] == 1'b0) && (q.csel_hi[11:0] == 12'h000) &&
    (q.src[15] == 1'b0) && (q.src[1:0] == 2'h0))
    else $error("reserved select or source bit set");
  chk_pair01_masked: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.csel_lo[14] | q.csel_lo[13]) |-> !slot_en[2])
    else $error("pair01 enabled with single-ended bit set");
  chk_pair23_masked: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.csel_lo[11] | q.csel_lo[10]) |-> !slot_en[5])
    else $error("pair23 enabled with single-ended bit set");
  chk_start_enabled: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.seq == acs_pkg::SEQ_SCAN && slot_en[q.slot]) |=>
    (conv_req.start && conv_req.chan == slot_chan($past(q.slot))))
    else $error("enabled slot not converted");
  chk_result_signed: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (result.we && result.twos) |->
    (result.idx == 4'h0 || result.idx == 4'h2))
    else $error("signed result in wrong register");
  chk_pair_chan: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (conv_req.start && conv_req.diff) |->
    (conv_req.chan == 4'h0 || conv_req.chan == 4'h2))
    else $error("differential request on wrong input");
  chk_overtemp_all: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.flags[2] && q.src[2]) |=> (dac_clear == 12'hFFF))
    else $error("overtemp did not clear all dacs");
  chk_source_gate: assert property (
    @(posedge aclk) disable iff (!aresetn)
    ((q.flags[14:3] & q.src[14:3]) == 12'h000 &&
    !(q.flags[2] && q.src[2]) && q.swclr == 16'h0000) |=>
    (dac_clear == 12'h000))
    else $error("unsourced alarm cleared a dac");
  chk_swclr_forces: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.swclr[14:3] != 12'h000) |=>
    ((dac_clear & $past(q.swclr[14:3])) == $past(q.swclr[14:3])))
    else $error("software clear not applied");
  chk_clear_release: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (q.flags == 16'h0000 && q.swclr == 16'h0000) |=> (dac_clear == 12'h000))
    else $error("dac clear without cause");
  chk_reset_values: assert property (
    @(posedge aclk) disable iff (!aresetn)
    $rose(aresetn) |->
    (input_range_bit == acs_pkg::RST_RANGE && q.src == acs_pkg::RST_SRC &&
    q.aen == acs_pkg::RST_DAC))
    else $error("register reset value wrong");
  chk_unlatched_follow: assert property (
    @(posedge aclk) disable iff (!aresetn)
    q.actl[2] |=> (q.flags == ($past(alarm_cond) & 16'h7FFC)))
    else $error("unlatched flags do not follow condition");
  chk_latched_hold: assert property (
    @(posedge aclk) disable iff (!aresetn)
    (!q.actl[2] && q.flags[2] && alarm_cond[2]) |=> q.flags[2])
    else $error("latched flag dropped while condition present");

endmodule
`default_nettype wire

// *** sim/tb_adc_sequence_and_dac_autoclear.sv ***
// self-checking testbench for the converter sequence and dac clear block
`timescale 1ns/1ps
`default_nettype none
module tb_adc_sequence_and_dac_autoclear;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic [11:0] s_axi_awaddr, s_axi_araddr, conv_data, dac_clear;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, rs;
  logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
  logic s_axi_arready, s_axi_rvalid, s_axi_rready, cycle_done, conv_done;
  logic [15:0] alarm_cond, input_range_bit;
  acs_pkg::acs_conv_s conv_req;
  acs_pkg::acs_res_s result;
  int failures = 0;
  int checks_done = 0;
  int pend = 0;
  logic [5:0] sq[$];
  logic [16:0] rq[$];

  acs_top #(.ADDR_W(12)) u_dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .alarm_cond,
    .cycle_done, .conv_done, .conv_data, .conv_req, .result,
    .input_range_bit, .dac_clear);

  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  // converter stand-in answers three cycles after a start; log traffic
  always @(posedge aclk) begin
    conv_done <= 1'b0;
    if (pend > 0) begin
      pend <= pend - 1;
      conv_done <= (pend == 1);
    end else if (conv_req.start) begin
      pend <= 3;
      conv_data <= {8'hA5, conv_req.chan};
    end
    if (conv_req.start)
      sq.push_back({conv_req.chan, conv_req.diff, conv_req.range});
    if (result.we)
      rq.push_back({result.idx, result.twos, result.data});
  end

  task automatic chk(input string nm, input logic [31:0] e, g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one axi write; address and data offered together, bready held
  task automatic axi_wr(input logic [7:0] idx, input logic [15:0] d);
    int t;
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    t = 0;
    @(posedge aclk);
    s_axi_awaddr <= {2'h0, idx, 2'h0};
    s_axi_wdata <= {16'h0000, d};
    s_axi_wstrb <= 4'h3;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw_ok && w_ok) && t < 100) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_ok = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_ok = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
      t++;
    end
    while (!s_axi_bvalid && t < 200) begin
      @(posedge aclk);
      t++;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk("bvalid", 32'h1, {31'h0, s_axi_bvalid});
  endtask

  // one axi read; rready held until rvalid is seen
  task automatic axi_rd(input logic [7:0] idx);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_araddr <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!(s_axi_arvalid && s_axi_arready) && t < 100) begin
      @(posedge aclk);
      t++;
    end
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid && t < 200) begin
      @(posedge aclk);
      t++;
    end
    rd = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk("rvalid", 32'h1, {31'h0, s_axi_rvalid});
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] idx,
                        input logic [31:0] e);
    axi_rd(idx);
    chk(nm, e, rd);
  endtask

  task automatic dac_chk(input logic [11:0] e);
    repeat (3) @(posedge aclk);
    chk("dac_clear", {20'h0, e}, {20'h0, dac_clear});
  endtask

  task automatic set_alarm(input logic [15:0] v);
    @(posedge aclk);
    alarm_cond <= v;
  endtask

  // reset values, reserved bits, unmapped access, range register
  task automatic t_regs;
    rd_chk("range", acs_pkg::IDX_RANGE, 32'h0000FFFF);
    rd_chk("source", acs_pkg::IDX_SRC, 32'h00000004);
    rd_chk("enable", acs_pkg::IDX_AEN, 32'h00000000);
    rd_chk("swclr", acs_pkg::IDX_SWCLR, 32'h00000000);
    chk("range_out", 32'h0000FFFF, {16'h0, input_range_bit});
    axi_wr(acs_pkg::IDX_CSEL_LO, 16'hFFFF);
    axi_wr(acs_pkg::IDX_CSEL_HI, 16'hFFFF);
    axi_wr(acs_pkg::IDX_SRC, 16'hFFFF);
    axi_wr(acs_pkg::IDX_AEN, 16'hFFFF);
    rd_chk("csel_lo", acs_pkg::IDX_CSEL_LO, 32'h00007FFF);
    rd_chk("csel_hi", acs_pkg::IDX_CSEL_HI, 32'h00007000);
    rd_chk("source", acs_pkg::IDX_SRC, 32'h00007FFC);
    rd_chk("enable", acs_pkg::IDX_AEN, 32'h00007FF8);
    axi_wr(acs_pkg::IDX_CSEL_LO, 16'h0000);
    axi_wr(acs_pkg::IDX_CSEL_HI, 16'h0000);
    rd_chk("unmapped", 8'h40, 32'h00000000);
    chk("rresp", {30'h0, acs_pkg::RESP_SLVERR}, {30'h0, rs});
    axi_wr(8'h40, 16'h1234);
    chk("bresp", {30'h0, acs_pkg::RESP_SLVERR}, {30'h0, rs});
    axi_wr(acs_pkg::IDX_RANGE, 16'h8001);
    chk("bresp", {30'h0, acs_pkg::RESP_OKAY}, {30'h0, rs});
    chk("range_out", 32'h00008001, {16'h0, input_range_bit});
  endtask

  // scan one selection; entries are {chan, diff, range}
  task automatic run_seq(input logic [15:0] lo, hi, input int n,
                         input logic [5:0] e[5]);
    int t;
    t = 0;
    sq.delete();
    rq.delete();
    axi_wr(acs_pkg::IDX_CSEL_LO, lo);
    axi_wr(acs_pkg::IDX_CSEL_HI, hi);
    while (rq.size() < n && t < 500) begin
      @(posedge aclk);
      t++;
    end
    axi_wr(acs_pkg::IDX_CSEL_LO, 16'h0000);
    axi_wr(acs_pkg::IDX_CSEL_HI, 16'h0000);
    repeat (20) @(posedge aclk);
    for (int i = 0; i < n; i++) begin
      chk("conv_req", {26'h0, e[i]}, {26'h0, sq[i]});
      chk("result", {15'h0, e[i][5:1], 8'hA5, e[i][5:2]}, rq[i]);
    end
  endtask

  // alarm routing to dac clears, unlatched then latched flags
  task automatic t_clear;
    // back to overtemp-only sourcing after the reserved-bit writes
    axi_wr(acs_pkg::IDX_SRC, 16'h0004);
    axi_wr(acs_pkg::IDX_AEN, 16'h0018);
    axi_wr(acs_pkg::IDX_ALARM_CTRL, 16'h0004);
    set_alarm(16'h4000);
    dac_chk(12'h000);
    rd_chk("status", acs_pkg::IDX_STATUS, 32'h00004000);
    axi_wr(acs_pkg::IDX_SRC, 16'h4004);
    dac_chk(12'h003);
    set_alarm(16'h0000);
    dac_chk(12'h000);
    set_alarm(16'h0004);
    dac_chk(12'hFFF);
    axi_wr(acs_pkg::IDX_SRC, 16'h4000);
    dac_chk(12'h000);
    set_alarm(16'h0000);
    axi_wr(acs_pkg::IDX_SWCLR, 16'h4008);
    dac_chk(12'h801);
    axi_wr(acs_pkg::IDX_SWCLR, 16'h0000);
    axi_wr(acs_pkg::IDX_SRC, 16'h2000);
    axi_wr(acs_pkg::IDX_ALARM_CTRL, 16'h0000);
    set_alarm(16'h2000);
    cycle_done <= 1'b1;
    set_alarm(16'h0000);
    cycle_done <= 1'b0;
    dac_chk(12'h003);
    rd_chk("status", acs_pkg::IDX_STATUS, 32'h00002000);
    rd_chk("status", acs_pkg::IDX_STATUS, 32'h00000000);
    dac_chk(12'h000);
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // watchdog against a hung handshake
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    summarize();
  end

  // main sequence
  initial begin
    logic [5:0] ea[5];
    logic [5:0] eb[5];
    ea = '{6'h01, 6'h0A, 6'h10, 6'h30, 6'h3D};
    eb = '{6'h03, 6'h0C, 6'h00, 6'h00, 6'h00};
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, cycle_done} = 3'h0;
    s_axi_awaddr = 12'h000;
    s_axi_araddr = 12'h000;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    alarm_cond = 16'h0000;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    run_seq(16'h5301, 16'h1000, 5, ea);
    run_seq(16'h1600, 16'h0000, 2, eb);
    t_clear();
    summarize();
  end
endmodule
`default_nettype wire
